// ---- rtl/osc_cfg_pkg.sv ----
// Behaviour
// - lf crystal load field bits 7:4; 0000 about 2 pF, else code+12 pF; reset 1100.
// - lf crystal bias field bits 1:0, 70/100/140/200 percent; reset 11.
// - lf config bit 7 reads the sampled 32 kHz pin level, read only.
// - lf config bit 2 selects crystal (1) or rc (0) source; reset 0.
// - lf config bit 1 powers the internal rc oscillator; reset 1.
// - lf config bit 0 powers the external crystal oscillator; reset 0.
// - eight-bit writable hf rc trim value, reset 00000000.
// - hf crystal load field bits 6:4, twice code plus 10 pF; reset 011.
// - hf crystal bias field bits 1:0, 75/100/125/150 percent; reset 01.
// - calibration counts system clocks over five lf periods; 12-bit result, top bits zero.
// - calibration control bit 0 enables the counter; reset 0.
// - calibration control bit 1 reads 1 while paused, 0 while counting; reset 1.
// - pll setup bit 7 reads the pll lock indicator.
// - rtc flag bit 7 is set when trigger mode fires; reset 0.
// - rtc flag bit 6 is set when the timing period elapses; reset 0.
// - rtc flag bit 5 reads 1 while trigger mode is disabled; reset 1.
// - with trigger mode on, writing 1 to bit 5 clears the trigger flag, bit self-clears.
// - bit 4 reads 1 with timing off; when on, writing 1 clears timing flag, self-clears.
package osc_cfg_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] off_lf_crystal_tune = 8'h00;
  localparam logic [7:0] off_lf_osc_config = 8'h04;
  localparam logic [7:0] off_hf_rc_trim = 8'h08;
  localparam logic [7:0] off_hf_crystal_tune = 8'h0c;
  localparam logic [7:0] off_osc_calibration_count = 8'h10;
  localparam logic [7:0] off_osc_calibration_control = 8'h14;
  localparam logic [7:0] off_pll_setup = 8'h18;
  localparam logic [7:0] off_rtc_event_flags = 8'h1c;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [3:0] rst_lf_load_cap_sel = 4'hc;
  localparam logic [1:0] rst_lf_bias_sel = 2'h3;
  localparam logic rst_lf_source_is_crystal = 1'b0;
  localparam logic rst_lf_rc_power_on = 1'b1;
  localparam logic rst_lf_crystal_power_on = 1'b0;
  localparam logic [7:0] rst_hf_rc_trim = 8'h00;
  localparam logic [2:0] rst_hf_load_cap_sel = 3'h3;
  localparam logic [1:0] rst_hf_bias_sel = 2'h1;
  localparam logic [1:0] rst_pll_param = 2'h0;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int pos_lf_load_cap_sel = 4;
  localparam int pos_lf_pin_level = 7;
  localparam int pos_lf_source_is_crystal = 2;
  localparam int pos_lf_rc_power_on = 1;
  localparam int pos_lf_crystal_power_on = 0;
  localparam int pos_hf_load_cap_sel = 4;
  localparam int pos_calibration_paused = 1;
  localparam int pos_calibration_enable = 0;
  localparam int pos_pll_lock_ind = 7;
  localparam int pos_alarm_hit_flag = 7;
  localparam int pos_period_hit_flag = 6;
  localparam int pos_alarm_flag_clear = 5;
  localparam int pos_period_flag_clear = 4;

  // ----------------------------------------
  // calibration timing
  // ----------------------------------------
  localparam int cal_periods = 5;
  localparam int cal_width = 12;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] lf_load_cap_sel;
    logic [1:0] lf_bias_sel;
    logic lf_source_is_crystal;
    logic lf_rc_power_on;
    logic lf_crystal_power_on;
    logic [7:0] hf_rc_trim;
    logic [2:0] hf_load_cap_sel;
    logic [1:0] hf_bias_sel;
    logic [1:0] pll_param;
  } osc_ctrl_t;

  typedef enum logic [1:0] {
    cal_idle = 2'b00,
    cal_wait_edge = 2'b01,
    cal_count = 2'b10
  } cal_state_t;

endpackage

// ---- rtl/oscillator_clock_config.sv ----
`timescale 1ns/10ps
`default_nettype none
module oscillator_clock_config (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic low_freq_clock,
  input wire logic lf_clk_pin,
  input wire logic pll_locked_raw,
  input wire logic trigger_mode_en,
  input wire logic timing_mode_en,
  input wire logic trigger_fire,
  input wire logic period_elapsed,
  output var osc_cfg_pkg::osc_ctrl_t osc_ctrl
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic w_strb0;
  logic w_held;
  logic do_write;
  logic rd_ok;
  logic wr_ok;
  logic [31:0] rd_word;
  logic [1:0] pin_sync;
  logic [2:0] lf_sync;
  logic [1:0] lock_sync;
  logic lf_rise;
  logic calibration_enable;
  logic calibration_paused;
  logic [11:0] calibration_result;
  logic [11:0] cal_cnt;
  logic [2:0] cal_edges;
  osc_cfg_pkg::cal_state_t cal_state;
  logic alarm_hit_flag;
  logic period_hit_flag;
  logic alarm_flag_clear;
  logic period_flag_clear;
  logic wr_flags;
  logic wr_alarm_clr;
  logic wr_period_clr;
  logic cal_start;
  logic rd_flags_sel;

  // one map decode shared by the read and write channels
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == osc_cfg_pkg::off_lf_crystal_tune) || (a == osc_cfg_pkg::off_lf_osc_config)
      || (a == osc_cfg_pkg::off_hf_rc_trim) || (a == osc_cfg_pkg::off_hf_crystal_tune)
      || (a == osc_cfg_pkg::off_osc_calibration_count) || (a == osc_cfg_pkg::off_osc_calibration_control)
      || (a == osc_cfg_pkg::off_pll_setup) || (a == osc_cfg_pkg::off_rtc_event_flags);
  endfunction

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_ok = addr_known({aw_addr[7:2], 2'b00});

  // capture address and data in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb0 <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10; // slverr on unmapped
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_ctrl.lf_load_cap_sel <= osc_cfg_pkg::rst_lf_load_cap_sel;
      osc_ctrl.lf_bias_sel <= osc_cfg_pkg::rst_lf_bias_sel;
      osc_ctrl.lf_source_is_crystal <= osc_cfg_pkg::rst_lf_source_is_crystal;
      osc_ctrl.lf_rc_power_on <= osc_cfg_pkg::rst_lf_rc_power_on;
      osc_ctrl.lf_crystal_power_on <= osc_cfg_pkg::rst_lf_crystal_power_on;
      osc_ctrl.hf_rc_trim <= osc_cfg_pkg::rst_hf_rc_trim;
      osc_ctrl.hf_load_cap_sel <= osc_cfg_pkg::rst_hf_load_cap_sel;
      osc_ctrl.hf_bias_sel <= osc_cfg_pkg::rst_hf_bias_sel;
      osc_ctrl.pll_param <= osc_cfg_pkg::rst_pll_param;
      calibration_enable <= 1'b0;
    end
    else if (do_write && w_strb0)
    begin
      if ({aw_addr[7:2], 2'b00} == osc_cfg_pkg::off_lf_crystal_tune)
      begin
        osc_ctrl.lf_load_cap_sel <= w_data[osc_cfg_pkg::pos_lf_load_cap_sel +: 4];
        osc_ctrl.lf_bias_sel <= w_data[1:0];
      end
      else if ({aw_addr[7:2], 2'b00} == osc_cfg_pkg::off_lf_osc_config)
      begin
        osc_ctrl.lf_source_is_crystal <= w_data[osc_cfg_pkg::pos_lf_source_is_crystal];
        osc_ctrl.lf_rc_power_on <= w_data[osc_cfg_pkg::pos_lf_rc_power_on];
        osc_ctrl.lf_crystal_power_on <= w_data[osc_cfg_pkg::pos_lf_crystal_power_on];
      end
      else if ({aw_addr[7:2], 2'b00} == osc_cfg_pkg::off_hf_rc_trim)
        osc_ctrl.hf_rc_trim <= w_data[7:0];
      else if ({aw_addr[7:2], 2'b00} == osc_cfg_pkg::off_hf_crystal_tune)
      begin
        osc_ctrl.hf_load_cap_sel <= w_data[osc_cfg_pkg::pos_hf_load_cap_sel +: 3];
        osc_ctrl.hf_bias_sel <= w_data[1:0];
      end
      else if ({aw_addr[7:2], 2'b00} == osc_cfg_pkg::off_osc_calibration_control)
        calibration_enable <= w_data[osc_cfg_pkg::pos_calibration_enable];
      else if ({aw_addr[7:2], 2'b00} == osc_cfg_pkg::off_pll_setup)
        osc_ctrl.pll_param <= w_data[1:0];
    end
  end

  // ----------------------------------------
  // synchronisers for asynchronous inputs
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_sync <= 2'b00;
      lf_sync <= 3'b000;
      lock_sync <= 2'b00;
    end
    else
    begin
      pin_sync <= {pin_sync[0], lf_clk_pin};
      lf_sync <= {lf_sync[1:0], low_freq_clock};
      lock_sync <= {lock_sync[0], pll_locked_raw};
    end
  end

  // edge seen only between second and third stage
  assign lf_rise = lf_sync[1] && !lf_sync[2];

  // ----------------------------------------
  // calibration counter
  // ----------------------------------------
  // a 0 to 1 write of the enable bit starts one run
  assign wr_flags = do_write && w_strb0 && ({aw_addr[7:2], 2'b00} == osc_cfg_pkg::off_osc_calibration_control);
  assign cal_start = wr_flags && w_data[osc_cfg_pkg::pos_calibration_enable] && !calibration_enable;
  assign calibration_paused = (cal_state == osc_cfg_pkg::cal_idle);

  // enable rising starts one measurement of five lf periods
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cal_state <= osc_cfg_pkg::cal_idle;
      cal_cnt <= 12'h000;
      cal_edges <= 3'h0;
      calibration_result <= 12'h000;
    end
    else
    begin
      case (cal_state)
        osc_cfg_pkg::cal_idle:
          if (cal_start)
            cal_state <= osc_cfg_pkg::cal_wait_edge;
        osc_cfg_pkg::cal_wait_edge:
          if (!calibration_enable)
            cal_state <= osc_cfg_pkg::cal_idle;
          else if (lf_rise)
          begin
            cal_cnt <= 12'h001;
            cal_edges <= 3'h0;
            cal_state <= osc_cfg_pkg::cal_count;
          end
        osc_cfg_pkg::cal_count:
          if (!calibration_enable)
            cal_state <= osc_cfg_pkg::cal_idle;
          else if (lf_rise && (cal_edges == 3'(osc_cfg_pkg::cal_periods - 1)))
          begin
            calibration_result <= cal_cnt;
            cal_state <= osc_cfg_pkg::cal_idle;
          end
          else
          begin
            cal_cnt <= cal_cnt + 12'h001;
            if (lf_rise)
              cal_edges <= cal_edges + 3'h1;
          end
        default:
          cal_state <= osc_cfg_pkg::cal_idle;
      endcase
    end
  end

  // ----------------------------------------
  // rtc event flags
  // ----------------------------------------
  // clear strobes act only while the matching rtc mode runs
  assign wr_alarm_clr = do_write && w_strb0 && ({aw_addr[7:2], 2'b00} == osc_cfg_pkg::off_rtc_event_flags)
    && w_data[osc_cfg_pkg::pos_alarm_flag_clear] && trigger_mode_en;
  assign wr_period_clr = do_write && w_strb0 && ({aw_addr[7:2], 2'b00} == osc_cfg_pkg::off_rtc_event_flags)
    && w_data[osc_cfg_pkg::pos_period_flag_clear] && timing_mode_en;
  assign alarm_flag_clear = !trigger_mode_en;
  assign period_flag_clear = !timing_mode_en;

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      alarm_hit_flag <= 1'b0;
      period_hit_flag <= 1'b0;
    end
    else
    begin
      if (trigger_fire)
        alarm_hit_flag <= 1'b1;
      else if (wr_alarm_clr)
        alarm_hit_flag <= 1'b0;
      if (period_elapsed)
        period_hit_flag <= 1'b1;
      else if (wr_period_clr)
        period_hit_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  // one read in flight; a new address waits until rready takes the data
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_ok = addr_known({s_axi_araddr[7:2], 2'b00});
  assign rd_flags_sel = s_axi_arvalid && s_axi_arready
    && ({s_axi_araddr[7:2], 2'b00} == osc_cfg_pkg::off_rtc_event_flags);
  assign rd_word =
    ({s_axi_araddr[7:2], 2'b00} == osc_cfg_pkg::off_lf_crystal_tune) ?
      {24'h0, osc_ctrl.lf_load_cap_sel, 2'b00, osc_ctrl.lf_bias_sel} :
    ({s_axi_araddr[7:2], 2'b00} == osc_cfg_pkg::off_lf_osc_config) ?
      {24'h0, pin_sync[1], 4'h0, osc_ctrl.lf_source_is_crystal, osc_ctrl.lf_rc_power_on,
       osc_ctrl.lf_crystal_power_on} :
    ({s_axi_araddr[7:2], 2'b00} == osc_cfg_pkg::off_hf_rc_trim) ? {24'h0, osc_ctrl.hf_rc_trim} :
    ({s_axi_araddr[7:2], 2'b00} == osc_cfg_pkg::off_hf_crystal_tune) ?
      {24'h0, 1'b0, osc_ctrl.hf_load_cap_sel, 2'b00, osc_ctrl.hf_bias_sel} :
    ({s_axi_araddr[7:2], 2'b00} == osc_cfg_pkg::off_osc_calibration_count) ?
      {20'h0, calibration_result} :
    ({s_axi_araddr[7:2], 2'b00} == osc_cfg_pkg::off_osc_calibration_control) ?
      {30'h0, calibration_paused, calibration_enable} :
    ({s_axi_araddr[7:2], 2'b00} == osc_cfg_pkg::off_pll_setup) ?
      {24'h0, lock_sync[1], 5'h00, osc_ctrl.pll_param} :
    ({s_axi_araddr[7:2], 2'b00} == osc_cfg_pkg::off_rtc_event_flags) ?
      {24'h0, alarm_hit_flag, period_hit_flag, alarm_flag_clear, period_flag_clear, 4'h0} :
    32'h0000_0000;

  // read data registered one cycle after address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // calibration sequencing and rtc flag set and clear
  a_cal_pause_start: assert property (@(posedge aclk) disable iff (!aresetn)
    cal_start |=> !calibration_paused) else $error("calibration did not leave pause");
  a_cal_off_pauses: assert property (@(posedge aclk) disable iff (!aresetn)
    !calibration_enable && !cal_start |=> calibration_paused) else $error("disabled counter not paused");
  a_result_held: assert property (@(posedge aclk) disable iff (!aresetn)
    calibration_paused && !cal_start |=> $stable(calibration_result)) else $error("result changed while paused");
  a_alarm_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    trigger_fire |=> alarm_hit_flag) else $error("trigger flag not set");
  a_period_set: assert property (@(posedge aclk) disable iff (!aresetn)
    period_elapsed |=> period_hit_flag) else $error("timing flag not set");
  a_alarm_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_alarm_clr && !trigger_fire |=> !alarm_hit_flag) else $error("trigger flag not cleared");
  a_period_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_period_clr && !period_elapsed |=> !period_hit_flag) else $error("timing flag not cleared");
  // clear control bits as the read channel returns them; pin sync depth; calibration period bound
  a_clear_bit_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_flags_sel |=> s_axi_rdata[osc_cfg_pkg::pos_alarm_flag_clear] == !$past(trigger_mode_en))
    else $error("trigger clear bit wrong");
  a_timing_clear_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_flags_sel |=> s_axi_rdata[osc_cfg_pkg::pos_period_flag_clear] == !$past(timing_mode_en))
    else $error("timing clear bit wrong");
  a_pin_two_stage: assert property (@(posedge aclk) disable iff (!aresetn)
    ##2 pin_sync[1] == $past(lf_clk_pin, 2)) else $error("pin sync depth wrong");
  a_cal_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    cal_state == osc_cfg_pkg::cal_count |-> cal_edges < 3'h5) else $error("too many lf periods");

  // synchroniser depth on the lf edge and on the lock level
  a_lf_edge_sync: assert property (@(posedge aclk) disable iff (!aresetn)
    lf_rise |-> $past(low_freq_clock, 2)) else $error("lf edge not two stages late");
  a_lock_two_stage: assert property (@(posedge aclk) disable iff (!aresetn)
    ##2 lock_sync[1] == $past(pll_locked_raw, 2)) else $error("lock sync depth wrong");

  // counter steps once a cycle and latches at the last lf edge
  a_cal_count_up: assert property (@(posedge aclk) disable iff (!aresetn)
    cal_state == osc_cfg_pkg::cal_count && calibration_enable && !lf_rise
    |=> cal_cnt == $past(cal_cnt) + 12'h001) else $error("calibration count did not step");
  a_result_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    cal_state == osc_cfg_pkg::cal_count && calibration_enable && lf_rise && (cal_edges == 3'(osc_cfg_pkg::cal_periods - 1))
    |=> calibration_result == $past(cal_cnt)) else $error("calibration result not latched");

  // responses stand until the master takes them
  a_bresp_stands: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_stands: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");

  // main scenarios reached by the bench
  c_cal_done: cover property (@(posedge aclk) disable iff (!aresetn)
    cal_state == osc_cfg_pkg::cal_count ##1 cal_state == osc_cfg_pkg::cal_idle);
  c_alarm_cleared: cover property (@(posedge aclk) disable iff (!aresetn) alarm_hit_flag ##1 !alarm_hit_flag);
  c_write_slverr: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bresp == 2'b10);
  c_cal_abort: cover property (@(posedge aclk) disable iff (!aresetn) !calibration_paused && !calibration_enable);
  c_period_cleared: cover property (@(posedge aclk) disable iff (!aresetn) period_hit_flag ##1 !period_hit_flag);

endmodule // oscillator_clock_config
`default_nettype wire

// ---- verification/oscillator_clock_config_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module oscillator_clock_config_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [2:0] s_axi_arprot = 3'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic low_freq_clock = 1'b0;
  logic lf_clk_pin = 1'b0;
  logic pll_locked_raw = 1'b0;
  logic trigger_mode_en = 1'b0;
  logic timing_mode_en = 1'b0;
  logic trigger_fire = 1'b0;
  logic period_elapsed = 1'b0;
  osc_cfg_pkg::osc_ctrl_t osc_ctrl;
  int err_total = 0;
  int comparisons = 0;

  // ----------------------------------------
  // clocks and device
  // ----------------------------------------
  always #5 aclk = ~aclk;

  // slow clock, 100 aclk cycles a period, edges kept off aclk edges
  initial
  begin
    #3;
    forever #500 low_freq_clock = ~low_freq_clock;
  end

  oscillator_clock_config DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .low_freq_clock, .lf_clk_pin, .pll_locked_raw,
    .trigger_mode_en, .timing_mode_en, .trigger_fire, .period_elapsed, .osc_ctrl
  );

  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task automatic print_verdict;
    $display("mismatches %0d, comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic timeout;
    err_total++;
    $display("mismatch at %0t: no answer in time", $time);
    print_verdict();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 100);
    if (s_axi_bvalid !== 1'b1) timeout();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 100);
    if (s_axi_rvalid !== 1'b1) timeout();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // write expecting an okay response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check({30'h0, r}, 32'h0);
  endtask

  // read expecting an okay response and a given word
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(d, exp);
    check({30'h0, r}, 32'h0);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic test_reset;
    logic [31:0] d;
    logic [1:0] r;
    check({8'h00, osc_ctrl}, {8'h00, 4'hc, 2'h3, 3'b010, 8'h00, 3'h3, 2'h1, 2'h0});
    rd_chk(osc_cfg_pkg::off_lf_crystal_tune, 32'hc3);
    rd_chk(osc_cfg_pkg::off_lf_osc_config, 32'h02);
    rd_chk(osc_cfg_pkg::off_hf_crystal_tune, 32'h31);
    axi_read(osc_cfg_pkg::off_osc_calibration_count, d, r);
    check(d & 32'hfffff000, 32'h0);
    rd_chk(osc_cfg_pkg::off_osc_calibration_control, 32'h02);
    rd_chk(osc_cfg_pkg::off_pll_setup, 32'h00);
    rd_chk(osc_cfg_pkg::off_rtc_event_flags, 32'h30);
  endtask

  task automatic test_rw;
    logic [31:0] d;
    logic [1:0] r;
    wr(osc_cfg_pkg::off_lf_crystal_tune, 32'hffffffff);
    rd_chk(osc_cfg_pkg::off_lf_crystal_tune, 32'hf3);
    wr(osc_cfg_pkg::off_lf_crystal_tune, 32'h5a);
    rd_chk(osc_cfg_pkg::off_lf_crystal_tune, 32'h52);
    wr(osc_cfg_pkg::off_lf_osc_config, 32'hfd);
    rd_chk(osc_cfg_pkg::off_lf_osc_config, 32'h05);
    wr(osc_cfg_pkg::off_hf_rc_trim, 32'ha5);
    rd_chk(osc_cfg_pkg::off_hf_rc_trim, 32'ha5);
    wr(osc_cfg_pkg::off_hf_crystal_tune, 32'hff);
    rd_chk(osc_cfg_pkg::off_hf_crystal_tune, 32'h73);
    wr(osc_cfg_pkg::off_pll_setup, 32'hff);
    rd_chk(osc_cfg_pkg::off_pll_setup, 32'h03);
    check({8'h00, osc_ctrl}, {8'h00, 4'h5, 2'h2, 3'b101, 8'ha5, 3'h7, 2'h3, 2'h3});
    // unmapped place answers with an error and zero data
    axi_write(8'h20, 32'h1, r);
    check({30'h0, r}, 32'h2);
    axi_read(8'h20, d, r);
    check({d[29:0], r}, 32'h2);
  endtask

  task automatic test_pins;
    @(posedge aclk);
    lf_clk_pin <= 1'b1;
    pll_locked_raw <= 1'b1;
    repeat (3) @(posedge aclk);
    rd_chk(osc_cfg_pkg::off_lf_osc_config, 32'h85);
    rd_chk(osc_cfg_pkg::off_pll_setup, 32'h83);
    lf_clk_pin <= 1'b0;
    pll_locked_raw <= 1'b0;
    repeat (3) @(posedge aclk);
    rd_chk(osc_cfg_pkg::off_lf_osc_config, 32'h05);
    rd_chk(osc_cfg_pkg::off_pll_setup, 32'h03);
  endtask

  task automatic test_calibration;
    logic [31:0] d;
    logic [31:0] first;
    logic [1:0] r;
    int n;
    n = 0;
    wr(osc_cfg_pkg::off_osc_calibration_control, 32'h1);
    rd_chk(osc_cfg_pkg::off_osc_calibration_control, 32'h01);
    do
    begin
      axi_read(osc_cfg_pkg::off_osc_calibration_control, d, r);
      n++;
    end
    while (d[1] !== 1'b1 && n < 600);
    if (d[1] !== 1'b1) timeout();
    axi_read(osc_cfg_pkg::off_osc_calibration_count, first, r);
    check({31'h0, (first >= 32'd499 && first <= 32'd501)}, 32'h1);
    repeat (150) @(posedge aclk);
    rd_chk(osc_cfg_pkg::off_osc_calibration_count, first);
    rd_chk(osc_cfg_pkg::off_osc_calibration_control, 32'h03);
    wr(osc_cfg_pkg::off_osc_calibration_control, 32'h0);
    rd_chk(osc_cfg_pkg::off_osc_calibration_control, 32'h02);
    // abort a run early; the last result stays
    wr(osc_cfg_pkg::off_osc_calibration_control, 32'h1);
    wr(osc_cfg_pkg::off_osc_calibration_control, 32'h0);
    rd_chk(osc_cfg_pkg::off_osc_calibration_control, 32'h02);
    rd_chk(osc_cfg_pkg::off_osc_calibration_count, first);
  endtask

  task automatic pulse_event(input bit alarm);
    @(posedge aclk);
    if (alarm) trigger_fire <= 1'b1;
    else period_elapsed <= 1'b1;
    @(posedge aclk);
    trigger_fire <= 1'b0;
    period_elapsed <= 1'b0;
  endtask

  task automatic test_flags;
    @(posedge aclk);
    trigger_mode_en <= 1'b1;
    timing_mode_en <= 1'b1;
    rd_chk(osc_cfg_pkg::off_rtc_event_flags, 32'h00);
    pulse_event(1'b1);
    rd_chk(osc_cfg_pkg::off_rtc_event_flags, 32'h80);
    pulse_event(1'b0);
    rd_chk(osc_cfg_pkg::off_rtc_event_flags, 32'hc0);
    wr(osc_cfg_pkg::off_rtc_event_flags, 32'h20);
    rd_chk(osc_cfg_pkg::off_rtc_event_flags, 32'h40);
    wr(osc_cfg_pkg::off_rtc_event_flags, 32'h10);
    rd_chk(osc_cfg_pkg::off_rtc_event_flags, 32'h00);
    trigger_mode_en <= 1'b0;
    timing_mode_en <= 1'b0;
    rd_chk(osc_cfg_pkg::off_rtc_event_flags, 32'h30);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    do_reset();
    test_reset();
    test_rw();
    test_pins();
    test_calibration();
    test_flags();
    do_reset();
    test_reset();
    print_verdict();
  end
endmodule // oscillator_clock_config_tb_top
`default_nettype wire
